// ==== pkg/fcct_defs.svh ====
// Constants for the fast core cycle timing block
`ifndef FCCT_DEFS_SVH
`define FCCT_DEFS_SVH
`define FCCT_CLKS_PER_CYC      4
`define FCCT_CLKS_CLASSIC     12
`define FCCT_TMR_FAST_CLKS     4
`define FCCT_TMR_SLOW_CLKS    12
`define FCCT_RATE_RST       1'h0
`define FCCT_ACC_W            32
`endif

// ==== pkg/fcct_pkg.sv ====
// Types for the fast core cycle timing block
package fcct_pkg;
    typedef enum logic [1:0] {
        FCCT_PH0 = 2'h0,
        FCCT_PH1 = 2'h1,
        FCCT_PH2 = 2'h3,
        FCCT_PH3 = 2'h2
    } fcct_phase_t;

    typedef enum logic [2:0] {
        FCCT_SUM_NOP = 3'h0,
        FCCT_SUM_LD  = 3'h1,
        FCCT_SUM_ADD = 3'h2,
        FCCT_SUM_SUB = 3'h3,
        FCCT_SUM_SHR = 3'h4,
        FCCT_SUM_SHL = 3'h5
    } fcct_sumop_t;

    typedef struct packed {
        fcct_sumop_t  op;
        logic [31:0]  operand;
        logic [4:0]   shamt;
    } fcct_sumreq_t;

    typedef struct packed {
        logic         sel;
        logic         wr;
        logic [15:0]  wdata;
    } fcct_dpreq_t;
endpackage : fcct_pkg

// ==== rtl/fcct_summer.sv ====
// 32-bit summation helper: add, subtract, shift in one instruction cycle
`timescale 1ns/100ps
`include "fcct_defs.svh"
module fcct_summer #(
    parameter int W = `FCCT_ACC_W
) (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  go,
    input  wire fcct_pkg::fcct_sumreq_t req,
    output logic [W-1:0]               acc_q
);
    initial begin
        if (W < 8 || W > 32) $error("fcct_summer: W out of range");
    end

    // Result lands one clock after go, well inside a four-clock cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            acc_q <= '0;
        end else if (go) begin
            case (req.op)
                fcct_pkg::FCCT_SUM_LD:  acc_q <= req.operand[W-1:0];
                fcct_pkg::FCCT_SUM_ADD: acc_q <= acc_q + req.operand[W-1:0];
                fcct_pkg::FCCT_SUM_SUB: acc_q <= acc_q - req.operand[W-1:0];
                fcct_pkg::FCCT_SUM_SHR: acc_q <= acc_q >> req.shamt;
                fcct_pkg::FCCT_SUM_SHL: acc_q <= acc_q << req.shamt;
                default:                acc_q <= acc_q;
            endcase
        end
    end

    chk_sum_add: assert property (@(posedge mclk) disable iff (sys_rst)
        go && req.op == fcct_pkg::FCCT_SUM_ADD |=>
        acc_q == $past(acc_q) + $past(req.operand[W-1:0]))
        else $error("summer add result wrong");
endmodule : fcct_summer

// ==== rtl/fcct_core_timing.sv ====
// Cycle timing, timer tick, dual pointers, summer and idle gating
// Summary of operation
// - Instruction results match the classic core; only cycle timing changes.
// - Each machine cycle takes 4 clocks instead of 12.
// - Timer ticks every 12 clocks by default, optionally every 4.
// - Two independent data pointers, one selected for use.
// - 32-bit add, subtract and shift done within a few cycles.
// - Idle stops CPU and selected peripheral clocks by gating enables.
`timescale 1ns/100ps
`include "fcct_defs.svh"
module fcct_core_timing #(
    parameter int NPER = 4
) (
    input  wire logic                   mclk,
    input  wire logic                   sys_rst,
    input  wire logic                   rate_wr,
    input  wire logic                   rate_fast,
    input  wire logic                   idle_req,
    input  wire logic                   wake,
    input  wire logic [NPER-1:0]        per_off,
    input  wire fcct_pkg::fcct_dpreq_t  dp_req,
    input  wire logic                   sum_go,
    input  wire fcct_pkg::fcct_sumreq_t sum_req,
    output logic                        cyc_end_q,
    output fcct_pkg::fcct_phase_t       phase_q,
    output logic                        tmr_tick_q,
    output logic                        rate_fast_q,
    output logic [15:0]                 dp_active_q,
    output logic [15:0]                 dp0_q,
    output logic [15:0]                 dp1_q,
    output logic                        dp_sel_q,
    output logic                        cpu_en_q,
    output logic [NPER-1:0]             per_en_q,
    output logic                        idle_q,
    output logic [`FCCT_ACC_W-1:0]      sum_q
);
    initial begin
        if (NPER < 1 || NPER > 16) $error("fcct_core_timing: bad NPER");
    end

    logic [3:0] tdiv_q;
    logic [3:0] tdiv_lim;
    fcct_pkg::fcct_phase_t phase_d;

    // Helpers for the slow tick check: gap since the last tick, and
    // whether the rate bit stayed slow for the whole gap
    logic [3:0] tick_gap_q;
    logic       slow_span_q;

    // Rate bit; classic 12-clock timing after reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rate_fast_q <= `FCCT_RATE_RST;
        end else if (rate_wr) begin
            rate_fast_q <= rate_fast;
        end
    end

    // Gray walk of the four phases; frozen while idle
    always_comb begin
        case (phase_q)
            fcct_pkg::FCCT_PH0: phase_d = fcct_pkg::FCCT_PH1;
            fcct_pkg::FCCT_PH1: phase_d = fcct_pkg::FCCT_PH2;
            fcct_pkg::FCCT_PH2: phase_d = fcct_pkg::FCCT_PH3;
            default:            phase_d = fcct_pkg::FCCT_PH0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase_q   <= fcct_pkg::FCCT_PH0;
            cyc_end_q <= 1'b0;
        end else if (!idle_q) begin
            phase_q   <= phase_d;
            cyc_end_q <= (phase_q == fcct_pkg::FCCT_PH2);
        end else begin
            cyc_end_q <= 1'b0;
        end
    end

    // Timer prescaler keeps running in idle so timers can wake the core
    assign tdiv_lim = rate_fast_q ? 4'(`FCCT_TMR_FAST_CLKS - 1)
                                  : 4'(`FCCT_TMR_SLOW_CLKS - 1);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tdiv_q     <= 4'h0;
            tmr_tick_q <= 1'b0;
        end else if (tdiv_q >= tdiv_lim) begin
            tdiv_q     <= 4'h0;
            tmr_tick_q <= 1'b1;
        end else begin
            tdiv_q     <= tdiv_q + 4'h1;
            tmr_tick_q <= 1'b0;
        end
    end

    // Counts clocks between ticks; a counter stands in for a long
    // repetition that the assertion tools would have to unroll
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tick_gap_q  <= 4'h0;
            slow_span_q <= 1'b0;
        end else if (tmr_tick_q) begin
            tick_gap_q  <= 4'h0;
            slow_span_q <= !rate_fast_q;
        end else begin
            tick_gap_q  <= (tick_gap_q == 4'hf) ? 4'hf : tick_gap_q + 4'h1;
            slow_span_q <= slow_span_q && !rate_fast_q;
        end
    end

    // Two pointers; only the selected one is written or presented
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dp0_q    <= 16'h0000;
            dp1_q    <= 16'h0000;
            dp_sel_q <= 1'b0;
        end else begin
            dp_sel_q <= dp_req.sel;
            if (dp_req.wr && !dp_req.sel) dp0_q <= dp_req.wdata;
            if (dp_req.wr && dp_req.sel)  dp1_q <= dp_req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dp_active_q <= 16'h0000;
        end else if (dp_req.wr) begin
            dp_active_q <= dp_req.wdata;
        end else begin
            dp_active_q <= dp_req.sel ? dp1_q : dp0_q;
        end
    end

    // Idle: wake wins over a same-cycle request so no wake is lost
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            idle_q   <= 1'b0;
            cpu_en_q <= 1'b1;
            per_en_q <= {NPER{1'b1}};
        end else if (wake) begin
            idle_q   <= 1'b0;
            cpu_en_q <= 1'b1;
            per_en_q <= {NPER{1'b1}};
        end else if (idle_req) begin
            idle_q   <= 1'b1;
            cpu_en_q <= 1'b0;
            per_en_q <= ~per_off;
        end
    end

    // Summer result is the same arithmetic software would produce
    fcct_summer #(.W(`FCCT_ACC_W)) u_sum (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .go      (sum_go),
        .req     (sum_req),
        .acc_q   (sum_q)
    );

    chk_cycle_four: assert property (@(posedge mclk) disable iff (sys_rst)
        cyc_end_q && !idle_q |-> ##1 !cyc_end_q [*3] ##1 (cyc_end_q || idle_q)
        )
        else $error("machine cycle not four clocks");

    chk_tick_slow: assert property (
        @(posedge mclk) disable iff (sys_rst)
        tmr_tick_q && slow_span_q |->
        tick_gap_q == 4'(`FCCT_TMR_SLOW_CLKS - 1))
        else $error("slow timer tick not every twelve clocks");

    // A drop to the slow rate inside the window excuses a late tick
    chk_tick_fast: assert property (
        @(posedge mclk) disable iff (sys_rst)
        tmr_tick_q && rate_fast_q |->
        ##1 !tmr_tick_q [*3] ##1 (tmr_tick_q || !rate_fast_q))
        else $error("fast timer tick not every four clocks");

    chk_rate_reset: assert property (@(posedge mclk)
        $past(sys_rst) |-> !rate_fast_q)
        else $error("rate bit not cleared by reset");

    chk_dp_indep: assert property (@(posedge mclk) disable iff (sys_rst)
        dp_req.wr && !dp_req.sel |=> $stable(dp1_q))
        else $error("pointer one disturbed");

    chk_dp_write: assert property (@(posedge mclk) disable iff (sys_rst)
        dp_req.wr && dp_req.sel |=> dp1_q == $past(dp_req.wdata))
        else $error("pointer one write lost");

    chk_idle_gate: assert property (@(posedge mclk) disable iff (sys_rst)
        idle_req && !wake |=> !cpu_en_q && per_en_q == ~$past(per_off))
        else $error("idle gating wrong");

    chk_idle_freeze: assert property (@(posedge mclk) disable iff (sys_rst)
        idle_q && $past(idle_q) |-> $stable(phase_q) && !cyc_end_q)
        else $error("phase moved in idle");

    chk_sum_sub: assert property (@(posedge mclk) disable iff (sys_rst)
        sum_go && sum_req.op == fcct_pkg::FCCT_SUM_SUB |=>
        sum_q == $past(sum_q) - $past(sum_req.operand))
        else $error("summer subtract wrong");

    chk_cycle_gray: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !idle_q |=> $countones(phase_q ^ $past(phase_q)) == 1)
        else $error("phase step not one bit");

    chk_rate_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !rate_wr |=> $stable(rate_fast_q))
        else $error("rate bit moved without a write");

    chk_dp_select: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !dp_req.wr |=>
        dp_active_q == ($past(dp_req.sel) ? $past(dp1_q) : $past(dp0_q)))
        else $error("active pointer not the selected one");

    chk_wake_first: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wake |=> !idle_q && cpu_en_q && (&per_en_q))
        else $error("wake did not restore clocks");

    chk_cpu_idle: assert property (
        @(posedge mclk) disable iff (sys_rst)
        idle_q |-> !cpu_en_q)
        else $error("cpu clock running in idle");
endmodule : fcct_core_timing

// ==== testbench/fcct_core_timing_test.sv ====
// Self-checking bench for the fast core cycle timing block
`timescale 1ns/100ps
`include "fcct_defs.svh"
module fcct_core_timing_test;
    logic                   mclk, sys_rst, rate_wr, rate_fast;
    logic                   idle_req, wake, sum_go;
    logic [3:0]             per_off;
    fcct_pkg::fcct_dpreq_t  dp_req;
    fcct_pkg::fcct_sumreq_t sum_req;
    logic                   cyc_end_q, tmr_tick_q, rate_fast_q, dp_sel_q;
    logic                   cpu_en_q, idle_q;
    fcct_pkg::fcct_phase_t  phase_q;
    logic [15:0]            dp_active_q, dp0_q, dp1_q;
    logic [3:0]             per_en_q;
    logic [31:0]            sum_q;
    int                     error_cnt, samples_checked, n;

    fcct_core_timing #(.NPER(4)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .rate_wr(rate_wr), .rate_fast(rate_fast), .idle_req(idle_req),
        .wake(wake), .per_off(per_off), .dp_req(dp_req), .sum_go(sum_go),
        .sum_req(sum_req), .cyc_end_q(cyc_end_q), .phase_q(phase_q),
        .tmr_tick_q(tmr_tick_q), .rate_fast_q(rate_fast_q),
        .dp_active_q(dp_active_q), .dp0_q(dp0_q), .dp1_q(dp1_q),
        .dp_sel_q(dp_sel_q), .cpu_en_q(cpu_en_q), .per_en_q(per_en_q),
        .idle_q(idle_q), .sum_q(sum_q));

    // 125 MHz clock
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end

    // Inputs change 1 ns after the edge, so outputs have settled too
    task automatic step;
        @(posedge mclk);
        #1;
    endtask : step

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Edges between two pulses of the chosen strobe; bounded waits
    task automatic meas(input bit tick, output int cnt);
        int k;
        k = 0;
        while ((tick ? tmr_tick_q : cyc_end_q) !== 1'h1 && k < 40) begin
            step();
            k++;
        end
        cnt = 0;
        do begin
            step();
            cnt++;
        end while ((tick ? tmr_tick_q : cyc_end_q) !== 1'h1 && cnt < 40);
    endtask : meas

    task automatic set_rate(logic f);
        rate_wr = 1'h1;
        rate_fast = f;
        step();
        rate_wr = 1'h0;
        chk("rate_fast_q", {31'h0, f}, {31'h0, rate_fast_q});
    endtask : set_rate

    task automatic t_cycle;
        logic [1:0] p;
        meas(1'b0, n);
        chk("cycle_len", `FCCT_CLKS_PER_CYC, n);
        for (int i = 0; i < 4; i++) begin
            p = phase_q;
            step();
            chk("phase_gray", 32'h1, $countones(p ^ phase_q));
        end
    endtask : t_cycle

    task automatic t_timer;
        meas(1'b1, n);
        chk("tick_slow", `FCCT_TMR_SLOW_CLKS, n);
        set_rate(1'h1);
        meas(1'b1, n);
        meas(1'b1, n);
        chk("tick_fast", `FCCT_TMR_FAST_CLKS, n);
        set_rate(1'h0);
        meas(1'b1, n);
        meas(1'b1, n);
        chk("tick_slow2", `FCCT_TMR_SLOW_CLKS, n);
    endtask : t_timer

    // Back-to-back writes to both pointers, then selection alone
    task automatic t_ptr;
        dp_req = '{sel: 1'h0, wr: 1'h1, wdata: 16'h1234};
        step();
        dp_req = '{sel: 1'h1, wr: 1'h1, wdata: 16'habcd};
        step();
        dp_req = '{sel: 1'h0, wr: 1'h0, wdata: 16'h5555};
        chk("dp0", 32'h1234, {16'h0, dp0_q});
        chk("dp1", 32'habcd, {16'h0, dp1_q});
        chk("dp_sel", 32'h1, {31'h0, dp_sel_q});
        step();
        chk("dp_act0", 32'h1234, {16'h0, dp_active_q});
        dp_req.sel = 1'h1;
        step();
        chk("dp_act1", 32'habcd, {16'h0, dp_active_q});
    endtask : t_ptr

    // Every summer operation issued back to back, with wrap cases
    task automatic t_sum;
        fcct_pkg::fcct_sumop_t op [6];
        logic [31:0]           d  [6];
        logic [4:0]            sh [6];
        logic [31:0]           e  [6];
        op = '{fcct_pkg::FCCT_SUM_LD, fcct_pkg::FCCT_SUM_ADD,
               fcct_pkg::FCCT_SUM_SUB, fcct_pkg::FCCT_SUM_SHR,
               fcct_pkg::FCCT_SUM_SHL, fcct_pkg::FCCT_SUM_NOP};
        d  = '{32'hffff_fff0, 32'h20, 32'h11, 32'h0, 32'h0, 32'h7};
        sh = '{5'h0, 5'h0, 5'h0, 5'h4, 5'h1f, 5'h3};
        e  = '{32'hffff_fff0, 32'h10, 32'hffff_ffff, 32'h0fff_ffff,
               32'h8000_0000, 32'h8000_0000};
        for (int i = 0; i < 6; i++) begin
            sum_req = '{op: op[i], operand: d[i], shamt: sh[i]};
            sum_go = 1'h1;
            step();
            chk("sum_q", e[i], sum_q);
        end
        sum_go = 1'h0;
    endtask : t_sum

    task automatic t_idle;
        logic [1:0] p;
        per_off = 4'h5;
        idle_req = 1'h1;
        step();
        idle_req = 1'h0;
        chk("idle_q", 32'h1, {31'h0, idle_q});
        chk("cpu_en", 32'h0, {31'h0, cpu_en_q});
        chk("per_en", 32'ha, {28'h0, per_en_q});
        p = phase_q;
        meas(1'b1, n);
        chk("tick_idle", `FCCT_TMR_SLOW_CLKS, n);
        chk("phase_hold", {30'h0, p}, {30'h0, phase_q});
        chk("cyc_end_idle", 32'h0, {31'h0, cyc_end_q});
        wake = 1'h1;
        idle_req = 1'h1;
        step();
        wake = 1'h0;
        idle_req = 1'h0;
        chk("wake_idle", 32'h0, {31'h0, idle_q});
        chk("wake_cpu", 32'h1, {31'h0, cpu_en_q});
        chk("wake_per", 32'hf, {28'h0, per_en_q});
    endtask : t_idle

    task automatic tally_and_finish;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog: whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        error_cnt = 0;
        samples_checked = 0;
        {sys_rst, rate_wr, rate_fast, idle_req, wake, sum_go} = 6'h20;
        per_off = 4'h0;
        dp_req = '0;
        sum_req = '0;
        repeat (20) @(posedge mclk);
        #1;
        sys_rst = 1'h0;
        chk("rst_rate", `FCCT_RATE_RST, {31'h0, rate_fast_q});
        chk("rst_en", 32'h1f, {27'h0, cpu_en_q, per_en_q});
        t_cycle();
        t_timer();
        t_ptr();
        t_sum();
        t_idle();
        t_cycle();
        tally_and_finish();
    end
endmodule : fcct_core_timing_test
